// [sector_protection_map.svh]
`ifndef SECTOR_PROTECTION_MAP_SVH
`define SECTOR_PROTECTION_MAP_SVH

// apb register byte offsets
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_EXTSTAT 8'h10

// status register fields
`define ST_WIP_BIT 0
`define ST_LOCK_BIT 1
`define ST_PPB_BIT 2
`define ST_DYB_BIT 3
`define ST_PWMODE_BIT 4

// extended status fields, error and protect flags write one to clear
`define EX_WIP_BIT 0
`define EX_PERR_BIT 1
`define EX_EERR_BIT 2
`define EX_PROT_BIT 3

// unit layout
`define UNIT_COUNT 542
`define SECTOR_UNITS 32
`define BLOCK_UNITS 510
`define ADDR_W 25

// timing
`define CLK_PERIOD_NS 20
`define PPB_PROG_TIME_NS 200000
`define PPB_ERASE_TIME_NS 45000000
`define PPB_PROG_CYC ((`PPB_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PPB_ERASE_CYC ((`PPB_ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [sector_protection_pkg.sv]
package sector_protection_pkg;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_PROG_PPB = 4'h1,
    CMD_ERASE_PPB = 4'h2,
    CMD_READ_PPB = 4'h3,
    CMD_WRITE_DYNAMIC_BIT_COMMAND = 4'h4,
    CMD_CLEAR_LOCK = 4'h5,
    CMD_SOFT_RESET = 4'h6
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROG = 3'b001,
    ST_PREPROG = 3'b010,
    ST_VERIFY = 3'b011,
    ST_ERASE = 3'b100
  } state_t;

endpackage

// [sector_protection_bits.sv]
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "sector_protection_map.svh"

// Summary of operation
// - one non-volatile persistent bit per unit
// - program clears one bit, erase sets all
// - erase preprograms and verifies on its own
// - progress visible in status and extended status
// - program page-time, erase sector-time
// - lock zero rejects persistent program and erase
// - no array reads while programming persistent bit (read block is raised in ST_PROG only, not in erase ST_PREPROG)
// - erase takes no address, all units
// - read command returns addressed persistent bit
// - factory state of persistent bits is one
// - one volatile dynamic bit per unit
// - dynamic bit matters only if persistent erased
// - write dynamic command sets zero or one
// - dynamic bits change without limit
// - lock zero freezes, one allows changes
// - persistent mode: reset sets lock one
// - persistent mode: no command sets lock
// - password mode: reset clears lock zero
// - password mode: unlock success sets lock
// - either bit zero blocks program and erase
// - 542 units: 32 sectors, 510 blocks
// - command clears lock to zero
// - software reset leaves lock unchanged

module sector_protection_bits #(
  parameter int UNITS = `UNIT_COUNT,
  parameter int PROG_CYC = `PPB_PROG_CYC,
  parameter int ERASE_CYC = `PPB_ERASE_CYC,
  parameter bit TOP_SECTORS = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic password_mode_i,
  input wire logic password_ok_i,
  input wire logic [`ADDR_W-1:0] query_addr_i,
  output logic query_protected_o,
  output logic array_read_block_o,
  output logic busy_o
);
  import sector_protection_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte address to unit index, small sectors at one end
  function automatic logic [9:0] unit_of(input logic [`ADDR_W-1:0] a);
    logic [8:0] blk;
    logic [9:0] sec;
    blk = a[24:16];
    sec = {5'h00, a[16:12]};
    if (!TOP_SECTORS) begin
      if (blk < 9'h002) begin
        unit_of = sec;
      end else begin
        unit_of = {1'b0, blk} + 10'h01E;
      end
    end else begin
      if (blk >= 9'h1FE) begin
        unit_of = 10'h1FE + sec;
      end else begin
        unit_of = {1'b0, blk};
      end
    end
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `REG_CMD) || (a == `REG_ADDR) || (a == `REG_DATA) ||
              (a == `REG_STATUS) || (a == `REG_EXTSTAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  // no reset term: contents survive hardware reset, factory value all ones
  logic [UNITS-1:0] ppb_r = '1;
  logic [UNITS-1:0] ppb_nxt;
  logic [UNITS-1:0] dyb_r;
  logic [UNITS-1:0] dyb_nxt;
  logic lock_r;
  logic lock_nxt;
  state_t state_r;
  state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [`ADDR_W-1:0] addr_r;
  logic [`ADDR_W-1:0] addr_nxt;
  logic data_r;
  logic data_nxt;
  logic rd_ppb_r;
  logic rd_ppb_nxt;
  logic rd_dyb_r;
  logic rd_dyb_nxt;
  logic perr_r;
  logic perr_nxt;
  logic eerr_r;
  logic eerr_nxt;
  logic prot_r;
  logic prot_nxt;
  logic [9:0] pend_r;
  logic [9:0] pend_nxt;
  logic [31:0] prdata_nxt;
  logic qprot_nxt;
  logic busy_r;
  logic busy_nxt;
  logic rdblk_r;
  logic rdblk_nxt;
  logic [UNITS-1:0] unit_prot;

  logic wr_acc;
  logic rd_setup;
  logic cmd_go;
  cmd_t cmd;
  logic [9:0] cmd_unit;
  logic [9:0] q_unit;
  logic wip;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  assign wr_acc = psel_i && penable_i && pwrite_i && addr_ok(paddr_i);
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  // commands arriving while busy are dropped, not queued
  assign cmd_go = wr_acc && (paddr_i == `REG_CMD) && (state_r == ST_IDLE);
  assign cmd = cmd_t'(pwdata_i[3:0]);
  // unit base expected; low bits below unit granularity ignored
  assign cmd_unit = unit_of(addr_r);
  assign q_unit = unit_of(query_addr_i);
  assign wip = (state_r != ST_IDLE);

  // zero wait states: every register answers in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok(paddr_i);
  assign busy_o = busy_r;
  assign array_read_block_o = rdblk_r;

  ////////////////////////////////////////////////////////////////////////
  // protection bits and command sequencer

  always_comb begin
    ppb_nxt = ppb_r;
    dyb_nxt = dyb_r;
    lock_nxt = lock_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    rd_ppb_nxt = rd_ppb_r;
    rd_dyb_nxt = rd_dyb_r;
    perr_nxt = perr_r;
    eerr_nxt = eerr_r;
    prot_nxt = prot_r;
    addr_nxt = addr_r;
    data_nxt = data_r;

    if (wr_acc && (paddr_i == `REG_ADDR)) begin
      addr_nxt = pwdata_i[`ADDR_W-1:0];
    end
    if (wr_acc && (paddr_i == `REG_DATA)) begin
      data_nxt = pwdata_i[0];
    end
    // clear first so a same-cycle set below wins
    if (wr_acc && (paddr_i == `REG_EXTSTAT)) begin
      if (pwdata_i[`EX_PERR_BIT]) begin
        perr_nxt = 1'b0;
      end
      if (pwdata_i[`EX_EERR_BIT]) begin
        eerr_nxt = 1'b0;
      end
      if (pwdata_i[`EX_PROT_BIT]) begin
        prot_nxt = 1'b0;
      end
    end

    if (password_ok_i && password_mode_i) begin
      lock_nxt = 1'b1;
    end

    unique case (state_r)
      ST_IDLE: begin
        if (cmd_go) begin
          unique case (cmd)
            CMD_PROG_PPB: begin
              if (!lock_r) begin
                prot_nxt = 1'b1;
                perr_nxt = 1'b1;
              end else begin
                pend_nxt = cmd_unit;
                cnt_nxt = 32'h0000_0000;
                state_nxt = ST_PROG;
              end
            end
            CMD_ERASE_PPB: begin
              // whole set at once, address register not consulted
              if (!lock_r) begin
                prot_nxt = 1'b1;
                eerr_nxt = 1'b1;
              end else begin
                cnt_nxt = 32'h0000_0000;
                state_nxt = ST_PREPROG;
              end
            end
            CMD_READ_PPB: begin
              rd_ppb_nxt = ppb_r[cmd_unit];
              rd_dyb_nxt = dyb_r[cmd_unit];
            end
            CMD_WRITE_DYNAMIC_BIT_COMMAND: begin
              // no wear on volatile bits, so no count or wait
              dyb_nxt[cmd_unit] = data_r;
            end
            CMD_CLEAR_LOCK: begin
              lock_nxt = 1'b0;
            end
            CMD_SOFT_RESET: begin
              // lock deliberately untouched here
              dyb_nxt = '1;
            end
            default: begin
            end
          endcase
        end
      end
      ST_PROG: begin
        if (cnt_r == 32'(PROG_CYC - 1)) begin
          ppb_nxt[pend_r] = 1'b0;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      ST_PREPROG: begin
        // all cells to zero first so erase stress is even
        // limitation: hardware reset once this step has ended leaves units protected
        if (cnt_r == 32'(PROG_CYC - 1)) begin
          ppb_nxt = '0;
          cnt_nxt = 32'h0000_0000;
          state_nxt = ST_VERIFY;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      ST_VERIFY: begin
        if (ppb_r != '0) begin
          eerr_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (cnt_r == 32'(ERASE_CYC - 1)) begin
          ppb_nxt = '1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase

    if (!rst_n_i) begin
      // mode decides lock polarity after hardware reset
      lock_nxt = !password_mode_i;
      dyb_nxt = '1;
      state_nxt = ST_IDLE;
      cnt_nxt = 32'h0000_0000;
      pend_nxt = 10'h000;
      rd_ppb_nxt = 1'b1;
      rd_dyb_nxt = 1'b1;
      perr_nxt = 1'b0;
      eerr_nxt = 1'b0;
      prot_nxt = 1'b0;
      addr_nxt = '0;
      data_nxt = 1'b1;
    end
  end

  // only hardware reset raises lock in persistent mode; no command path does
  always_ff @(posedge clk_i) begin
    ppb_r <= ppb_nxt;
    dyb_r <= dyb_nxt;
    lock_r <= lock_nxt;
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    pend_r <= pend_nxt;
    rd_ppb_r <= rd_ppb_nxt;
    rd_dyb_r <= rd_dyb_nxt;
    perr_r <= perr_nxt;
    eerr_r <= eerr_nxt;
    prot_r <= prot_nxt;
    addr_r <= addr_nxt;
    data_r <= data_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // status outputs

  // taken from the next state, so they line up with state_r with no lag
  always_comb begin
    busy_nxt = (state_nxt != ST_IDLE);
    rdblk_nxt = (state_nxt == ST_PROG);
  end

  always_ff @(posedge clk_i) begin
    busy_r <= busy_nxt;
    rdblk_r <= rdblk_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-unit protection state

  // one gate pair per unit; the query mux then only picks one line
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    assign unit_prot[u] = !ppb_r[u] || !dyb_r[u];
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and protection query

  always_comb begin
    prdata_nxt = prdata_o;
    if (rd_setup) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr_i)
        `REG_ADDR: prdata_nxt[`ADDR_W-1:0] = addr_r;
        `REG_DATA: prdata_nxt[0] = data_r;
        `REG_STATUS: begin
          prdata_nxt[`ST_WIP_BIT] = wip;
          prdata_nxt[`ST_LOCK_BIT] = lock_r;
          prdata_nxt[`ST_PPB_BIT] = rd_ppb_r;
          prdata_nxt[`ST_DYB_BIT] = rd_dyb_r;
          prdata_nxt[`ST_PWMODE_BIT] = password_mode_i;
        end
        `REG_EXTSTAT: begin
          prdata_nxt[`EX_WIP_BIT] = wip;
          prdata_nxt[`EX_PERR_BIT] = perr_r;
          prdata_nxt[`EX_EERR_BIT] = eerr_r;
          prdata_nxt[`EX_PROT_BIT] = prot_r;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    // dynamic bit only counts once persistent bit is erased
    qprot_nxt = unit_prot[q_unit];
    if (!rst_n_i) begin
      prdata_nxt = 32'h0000_0000;
      qprot_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    prdata_o <= prdata_nxt;
    query_protected_o <= qprot_nxt;
  end

endmodule

// [sector_protection_bits_assertions.sv]
`timescale 1ns/1ps
module sector_protection_checker #(
  parameter int PROG_CYC = 8,
  parameter int ERASE_CYC = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic password_mode_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic array_read_block_o,
  input wire logic busy_o
);
  // loose window: exact edge of the done flag is the designer's choice
  localparam int PROG_LO = PROG_CYC - 1;
  localparam int PROG_HI = PROG_CYC + 1;
  localparam int BUSY_MAX = PROG_CYC + ERASE_CYC + 4;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_ready_always: assert property (pready_o) else $error("pready low");
  a_unmapped_error: assert property (psel_i && penable_i && paddr_i > 8'h10 |-> pslverr_o)
    else $error("no error on unmapped access");
  a_status_no_error: assert property (psel_i && penable_i && paddr_i == 8'h0C |-> !pslverr_o)
    else $error("error on status access");
  a_cmd_reads_zero: assert property (s_rd(8'h00) |=> prdata_o == 32'h0) else $error("command reads nonzero");
  a_status_wip: assert property (s_rd(8'h0C) |=> prdata_o[0] == $past(busy_o))
    else $error("wip differs from busy");
  a_status_mode: assert property (s_rd(8'h0C) |=> prdata_o[4] == $past(password_mode_i))
    else $error("mode bit wrong");
  a_block_needs_busy: assert property (array_read_block_o |-> busy_o)
    else $error("read block without busy");
  a_prog_duration: assert property ($rose(array_read_block_o) |-> ##[PROG_LO:PROG_HI] $fell(array_read_block_o))
    else $error("program length wrong");
  a_busy_bounded: assert property ($rose(busy_o) |-> ##[1:BUSY_MAX] !busy_o)
    else $error("busy too long");
endmodule
////////////////////////////////////////////////////////////////
bind sector_protection_bits sector_protection_checker #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .password_mode_i(password_mode_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .array_read_block_o(array_read_block_o), .busy_o(busy_o));

// [password_source.sv]
`timescale 1ns/1ps
// stands in for the external password compare: one success pulse per request edge
module password_source (
  input wire logic clk_i,
  input wire logic req_i,
  output logic password_ok_o
);
  logic seen_r = 1'h0;
  always @(posedge clk_i) begin
    seen_r <= req_i;
    password_ok_o <= req_i && !seen_r;
  end
endmodule

// [test_sector_protection_bits.sv]
`timescale 1ns/1ps
module test_sector_protection_bits;
  logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, password_mode_i, password_ok_i, req;
  logic pready_o, pslverr_o, query_protected_o, array_read_block_o, busy_o, err, top_prot;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [24:0] query_addr_i;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // short counts keep the run brief
  sector_protection_bits #(.PROG_CYC(8), .ERASE_CYC(16)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .password_mode_i(password_mode_i),
    .password_ok_i(password_ok_i), .query_addr_i(query_addr_i), .query_protected_o(query_protected_o),
    .array_read_block_o(array_read_block_o), .busy_o(busy_o));
  // second copy with the small sectors at the top end, fed the same stimulus
  sector_protection_bits #(.PROG_CYC(8), .ERASE_CYC(16), .TOP_SECTORS(1'b1)) i_top (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(), .pready_o(), .pslverr_o(), .password_mode_i(password_mode_i),
    .password_ok_i(password_ok_i), .query_addr_i(query_addr_i), .query_protected_o(top_prot),
    .array_read_block_o(), .busy_o());
  password_source i_host (.clk_i(clk_i), .req_i(req), .password_ok_o(password_ok_i));
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    @(posedge clk_i);
    while (pready_o !== 1'h1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task cmd(input logic [3:0] c, input logic [24:0] a, input logic d);
    apb(1'h1, 8'h04, {7'h0, a});
    apb(1'h1, 8'h08, {31'h0, d});
    apb(1'h1, 8'h00, {28'h0, c});
  endtask
  task status(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd & mask, exp);
  endtask
  task wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'h0 && n < 100) begin
      apb(1'h0, 8'h0C, 32'h0);
      n++;
    end
  endtask
  // output lags the address by one edge, so allow two
  task query(input logic [24:0] a, input logic e);
    @(posedge clk_i);
    query_addr_i <= a;
    repeat (2) @(posedge clk_i);
    chk({31'h0, query_protected_o}, {31'h0, e});
  endtask
  task hw_reset(input logic m);
    password_mode_i <= m;
    rst_n_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
  endtask
  task unlock;
    @(posedge clk_i);
    req <= 1'h1;
    @(posedge clk_i);
    req <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task end_of_test;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {psel_i, penable_i, pwrite_i, password_mode_i, req, rst_n_i} = 6'h0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    query_addr_i = 25'h0;
    hw_reset(1'h0);
    cmd(4'h3, 25'h0, 1'h0);
    status(32'h1F, 32'h0E);
    apb(1'h0, 8'h00, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset state done");
    cmd(4'h4, 25'h1000, 1'h0);
    query(25'h1000, 1'h1);
    query(25'h0, 1'h0);
    cmd(4'h3, 25'h1000, 1'h0);
    status(32'h0C, 32'h04);
    cmd(4'h4, 25'h1000, 1'h1);
    query(25'h1000, 1'h0);
    cmd(4'h4, 25'h1FE1000, 1'h0);
    query(25'h1FE0000, 1'h1);
    chk({31'h0, top_prot}, 32'h0);
    query(25'h1FE1000, 1'h1);
    chk({31'h0, top_prot}, 32'h1);
    $display("test dynamic bits done");
    cmd(4'h1, 25'h20000, 1'h0);
    @(negedge clk_i);
    chk({31'h0, array_read_block_o}, 32'h1);
    wait_idle;
    query(25'h20000, 1'h1);
    query(25'h30000, 1'h0);
    $display("test program done");
    cmd(4'h5, 25'h0, 1'h0);
    status(32'h02, 32'h0);
    cmd(4'h1, 25'h30000, 1'h0);
    wait_idle;
    query(25'h30000, 1'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd & 32'h0E, 32'h0A);
    cmd(4'h2, 25'h0, 1'h0);
    wait_idle;
    query(25'h20000, 1'h1);
    cmd(4'h6, 25'h0, 1'h0);
    unlock;
    status(32'h02, 32'h0);
    $display("test lock done");
    hw_reset(1'h1);
    status(32'h13, 32'h10);
    query(25'h20000, 1'h1);
    unlock;
    status(32'h13, 32'h12);
    cmd(4'h2, 25'h0, 1'h0);
    @(negedge clk_i);
    chk({31'h0, busy_o}, 32'h1);
    wait_idle;
    query(25'h20000, 1'h0);
    $display("test password mode done");
    end_of_test;
  end
endmodule
